//--- rtl/sla_pkg.sv
// Purpose: shared constants and types for the sysref/lmfc alignment block
// Assumes: 32-bit axi4-lite register word, one core clock
// Notes:   offsets are byte addresses
package sla_pkg;

  localparam int         SLA_ADDR_W       = 5;
  localparam logic [4:0] SLA_CTRL_OFS     = 5'h00;
  localparam logic [4:0] SLA_PERIOD_OFS   = 5'h04;
  localparam logic [4:0] SLA_STATUS_OFS   = 5'h08;
  localparam logic [4:0] SLA_FILL_OFS     = 5'h0C;

  // ctrl word: [0] realign_every [1] event_needed_on_resync
  // [2] subclass2 [3] link_sync_en [7:4] sysref delay
  // [8] soft reset (self clear) [9] resync request (self clear)
  localparam int         SLA_SOFT_RST_BIT = 8;
  localparam int         SLA_RESYNC_BIT   = 9;
  localparam logic [7:0] SLA_CTRL_RST     = 8'h0A;
  localparam logic [7:0] SLA_PERIOD_RST   = 8'h07;

  // status word layout
  localparam int         SLA_ST_SEEN      = 0;
  localparam int         SLA_ST_SYNC      = 1;
  localparam int         SLA_ST_REL       = 2;
  localparam int         SLA_ST_ILA       = 3;
  localparam int         SLA_ST_DATA      = 4;
  localparam int         SLA_ST_OVR       = 5;
  localparam int         SLA_ST_CNT_LSB   = 8;

  localparam int         SLA_DLY_MAX      = 15;
  localparam int         SLA_OCT_PER_CYC  = 4;
  localparam logic [1:0] SLA_ILA_MF       = 2'h3;
  localparam logic [1:0] SLA_RESP_OKAY    = 2'h0;
  localparam logic [1:0] SLA_RESP_DECERR  = 2'h3;

  typedef struct packed {
    logic [3:0] sysref_delay;
    logic       link_sync_en;
    logic       subclass2;
    logic       event_needed_on_resync;
    logic       realign_every;
  } sla_ctrl_t;

  typedef enum logic [3:0] {
    SLA_RX_REF = 4'h1,
    SLA_RX_CGS = 4'h2,
    SLA_RX_BND = 4'h4,
    SLA_RX_UP  = 4'h8
  } sla_rx_st_t;

  typedef enum logic [3:0] {
    SLA_TX_REF = 4'h1,
    SLA_TX_SYN = 4'h2,
    SLA_TX_BND = 4'h4,
    SLA_TX_RUN = 4'h8
  } sla_tx_st_t;

endpackage

//--- rtl/sla_core.sv
// Purpose: sysref capture, lmfc counter and link bring-up gating
// Assumes: inputs synchronous to aclk, axi4-lite register access
// Notes:   lane buffers sit outside; this block times their release
// Operation
// - realign_every 0: only first sysref after reset, or after a resync with event need, aligns lmfc
// - realign_every 1: every sysref event realigns the lmfc counter
// - rx aligns to sysref, then releases sync on boundary after cgs
// - rx holds sync asserted until an initial sysref event is seen
// - tx starts ila on an lmfc boundary after sync release
// - tx sends no ila before an initial sysref event after reset
// - resync without event need: rx releases sync on next boundary
// - resync without event need: tx starts ila on next boundary
// - resync with event need: rx realigns on sysref, then releases
// - resync with event need: tx realigns on sysref before ila
// - programmable 0..15 cycle delay from sysref event to lmfc reset
// - build option captures sysref on rising instead of falling edge
// - subclass 2: rx releases sync once aligned to idle characters
// - subclass 2: tx waits lmfc crossing, then ila or data per enable
// - rx holds lane data until next lmfc crossing, then releases
// - lane alignment tolerates up to 8 octets of skew
// - alignment buffer depth configurable, about one multiframe
// - buffering absorbs variable transceiver latency across restarts
// - lmfc steps through multiframe octets, marks each boundary not hit by a sysref realign
// - edge option touches only the first sysref flip-flop
// - four octets per cycle, lmfc advances four octets each cycle
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module sla_core
  import sla_pkg::*;
#(
  parameter int LMFC_W          = 8,
  parameter int ALIGN_BUF_DEPTH = 256,
  parameter int LANE_SKEW_OCT   = 8,
  parameter bit SYSREF_NEGEDGE  = 1'b1
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [sla_pkg::SLA_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [sla_pkg::SLA_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      sysref,
  input  wire logic                      cgs_done,
  input  wire logic                      lanes_valid,
  input  wire logic                      rx_resync_req,
  input  wire logic                      sync_n_in,
  output logic                           rx_sync_n,
  output logic                           rx_release,
  output logic                           tx_ila,
  output logic                           tx_data,
  output logic                           lmfc_edge
);
  import sla_pkg::*;

  localparam int BUF_WORDS = ALIGN_BUF_DEPTH / SLA_OCT_PER_CYC;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ALIGN_BUF_DEPTH % SLA_OCT_PER_CYC != 0 ||
      ALIGN_BUF_DEPTH < LANE_SKEW_OCT || LANE_SKEW_OCT > 8 ||
      BUF_WORDS > (1 << LMFC_W) || LMFC_W < 2 ||
      LMFC_W > 24) begin : g_bad
    $error("sla_core: unsupported parameter set");
  end

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  sla_ctrl_t          ctrl_q;
  logic [LMFC_W-1:0]  period_q;
  logic [SLA_ADDR_W-1:0] awaddr_q;
  logic [SLA_ADDR_W-1:0] araddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               sw_rst_q;
  logic               sw_resync_q;
  logic               do_wr;
  logic [31:0]        status;
  logic [31:0]        rd_word;
  logic [1:0]         rd_resp;
  logic [31:0]        wmask;
  logic               seen_q;
  logic               rx_rel_q;
  logic               ovr_q;
  logic [LMFC_W-1:0]  lmfc_cnt_q;
  logic [LMFC_W-1:0]  fill_q;

  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // address and data are taken independently; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SLA_RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == SLA_CTRL_OFS ||
                         awaddr_q == SLA_PERIOD_OFS ||
                         awaddr_q == SLA_STATUS_OFS ||
                         awaddr_q == SLA_FILL_OFS) ?
                        SLA_RESP_OKAY : SLA_RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ctrl and period survive the soft reset; the link logic and the fill count restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= SLA_CTRL_RST;
      period_q    <= LMFC_W'(SLA_PERIOD_RST);
      sw_rst_q    <= 1'b0;
      sw_resync_q <= 1'b0;
    end else begin
      sw_rst_q    <= 1'b0;
      sw_resync_q <= 1'b0;
      if (do_wr && awaddr_q == SLA_CTRL_OFS) begin
        ctrl_q      <= (ctrl_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
        sw_rst_q    <= wdata_q[SLA_SOFT_RST_BIT] & wstrb_q[1];
        sw_resync_q <= wdata_q[SLA_RESYNC_BIT] & wstrb_q[1];
      end
      if (do_wr && awaddr_q == SLA_PERIOD_OFS) begin
        period_q <= (period_q & ~wmask[LMFC_W-1:0]) |
                    (wdata_q[LMFC_W-1:0] & wmask[LMFC_W-1:0]);
      end
    end
  end

  always_comb begin
    status = '0;
    status[SLA_ST_SEEN] = seen_q;
    status[SLA_ST_SYNC] = rx_sync_n;
    status[SLA_ST_REL]  = rx_rel_q;
    status[SLA_ST_ILA]  = tx_ila;
    status[SLA_ST_DATA] = tx_data;
    status[SLA_ST_OVR]  = ovr_q;
    status[SLA_ST_CNT_LSB +: LMFC_W] = lmfc_cnt_q;
    rd_resp = SLA_RESP_OKAY;
    case (araddr_q)
      SLA_CTRL_OFS:   rd_word = {24'h000000, ctrl_q};
      SLA_PERIOD_OFS: rd_word = 32'(period_q);
      SLA_STATUS_OFS: rd_word = status;
      SLA_FILL_OFS:   rd_word = 32'(fill_q);
      default: begin
        rd_word = '0;
        rd_resp = SLA_RESP_DECERR;
      end
    endcase
  end

  // read data is sampled one cycle after the address is taken
  logic rd_pend_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= SLA_RESP_OKAY;
      araddr_q      <= '0;
      rd_pend_q     <= 1'b0;
    end else begin
      rd_pend_q <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        araddr_q      <= s_axi_araddr;
        rd_pend_q     <= 1'b1;
      end
      if (rd_pend_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_resp;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // sysref capture and event delay
  // ---------------------------------------------------------------
  logic core_rst;
  logic sref_cap_q;
  logic sref_r_q;
  logic sref_r2_q;
  logic evt;
  logic evt_dly;
  logic accept;
  logic rx_resync;
  logic tx_resync;
  logic lmfc_wrap;
  logic [SLA_DLY_MAX-1:0] dly_q;

  assign core_rst = !aresetn || sw_rst_q;

  if (SYSREF_NEGEDGE) begin : g_neg
    // falling edge gives margin when sysref is edge aligned to aclk
    always_ff @(negedge aclk) begin
      if (!aresetn) sref_cap_q <= 1'b0;
      else sref_cap_q <= sysref;
    end
  end else begin : g_pos
    always_ff @(posedge aclk) begin
      if (!aresetn) sref_cap_q <= 1'b0;
      else sref_cap_q <= sysref;
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      sref_r_q  <= 1'b0;
      sref_r2_q <= 1'b0;
      dly_q     <= '0;
    end else begin
      sref_r_q  <= sref_cap_q;
      sref_r2_q <= sref_r_q;
      dly_q     <= {dly_q[SLA_DLY_MAX-2:0], evt};
    end
  end

  assign evt     = sref_r_q && !sref_r2_q;
  assign evt_dly = (ctrl_q.sysref_delay == 4'h0) ? evt :
                   dly_q[ctrl_q.sysref_delay - 4'h1];
  // subclass 2 ignores sysref entirely
  assign accept  = evt_dly && !ctrl_q.subclass2 &&
                   (ctrl_q.realign_every || !seen_q);

  // ---------------------------------------------------------------
  // lmfc counter, one step is four octets
  // ---------------------------------------------------------------
  assign lmfc_wrap = (lmfc_cnt_q == period_q);

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      lmfc_cnt_q <= '0;
      lmfc_edge  <= 1'b0;
    end else begin
      lmfc_edge <= lmfc_wrap && !accept;
      if (accept || lmfc_wrap) lmfc_cnt_q <= '0;
      else lmfc_cnt_q <= lmfc_cnt_q + LMFC_W'(1);
    end
  end

  // seen record is only dropped on resync when a new event is demanded
  always_ff @(posedge aclk) begin
    if (core_rst) seen_q <= 1'b0;
    else if (accept) seen_q <= 1'b1;
    else if ((rx_resync || tx_resync) &&
             ctrl_q.event_needed_on_resync) seen_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // receiver bring-up
  // ---------------------------------------------------------------
  sla_rx_st_t rx_q;
  sla_rx_st_t rx_d;
  logic       lmfc_ok;
  logic [LMFC_W-1:0] fill_cnt_q;

  assign lmfc_ok   = seen_q || ctrl_q.subclass2;
  assign rx_resync = sw_resync_q || (rx_resync_req && rx_q == SLA_RX_UP);

  always_comb begin
    rx_d = rx_q;
    case (rx_q)
      SLA_RX_REF: if (lmfc_ok) rx_d = SLA_RX_CGS;
      SLA_RX_CGS: begin
        if (cgs_done) begin
          rx_d = ctrl_q.subclass2 ? SLA_RX_UP : SLA_RX_BND;
        end
      end
      SLA_RX_BND: begin
        if (!cgs_done) rx_d = SLA_RX_CGS;
        else if (lmfc_wrap) rx_d = SLA_RX_UP;
      end
      SLA_RX_UP: if (!cgs_done) rx_d = SLA_RX_CGS;
      default: rx_d = SLA_RX_REF;
    endcase
    if (rx_resync) begin
      rx_d = (ctrl_q.event_needed_on_resync && !ctrl_q.subclass2) ?
             SLA_RX_REF : SLA_RX_CGS;
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      rx_q      <= SLA_RX_REF;
      rx_sync_n <= 1'b0;
    end else begin
      rx_q      <= rx_d;
      rx_sync_n <= (rx_d == SLA_RX_UP);
    end
  end

  // buffered words counted until release; the count exposes how much
  // transceiver latency was absorbed so restarts can be compared
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      rx_rel_q   <= 1'b0;
      fill_cnt_q <= '0;
      fill_q     <= '0;
      ovr_q      <= 1'b0;
    end else if (rx_q != SLA_RX_UP || !lanes_valid || rx_resync) begin
      rx_rel_q   <= 1'b0;
      fill_cnt_q <= '0;
    end else if (!rx_rel_q) begin
      fill_cnt_q <= fill_cnt_q + LMFC_W'(1);
      if (lmfc_wrap) begin
        rx_rel_q <= 1'b1;
        fill_q   <= fill_cnt_q;
        ovr_q    <= (32'(fill_cnt_q) >= BUF_WORDS);
      end
    end
  end

  assign rx_release = rx_rel_q;

  // ---------------------------------------------------------------
  // transmitter bring-up
  // ---------------------------------------------------------------
  sla_tx_st_t tx_q;
  sla_tx_st_t tx_d;
  logic [1:0] ila_mf_q;

  assign tx_resync = (tx_q == SLA_TX_RUN) && !sync_n_in;

  always_comb begin
    tx_d = tx_q;
    case (tx_q)
      SLA_TX_REF: if (lmfc_ok) tx_d = SLA_TX_SYN;
      SLA_TX_SYN: if (sync_n_in) tx_d = SLA_TX_BND;
      SLA_TX_BND: begin
        if (!sync_n_in) tx_d = SLA_TX_SYN;
        else if (lmfc_wrap) tx_d = SLA_TX_RUN;
      end
      SLA_TX_RUN: begin
        if (!sync_n_in) begin
          tx_d = (ctrl_q.event_needed_on_resync && !ctrl_q.subclass2) ?
                 SLA_TX_REF : SLA_TX_SYN;
        end
      end
      default: tx_d = SLA_TX_REF;
    endcase
  end

  // ila covers a fixed number of multiframes, then user data follows
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      tx_q     <= SLA_TX_REF;
      tx_ila   <= 1'b0;
      tx_data  <= 1'b0;
      ila_mf_q <= '0;
    end else begin
      tx_q <= tx_d;
      if (tx_d != SLA_TX_RUN) begin
        tx_ila   <= 1'b0;
        tx_data  <= 1'b0;
        ila_mf_q <= '0;
      end else if (tx_q != SLA_TX_RUN) begin
        tx_ila  <= ctrl_q.link_sync_en;
        tx_data <= !ctrl_q.link_sync_en;
      end else if (tx_ila && lmfc_wrap) begin
        ila_mf_q <= ila_mf_q + 2'h1;
        if (ila_mf_q == SLA_ILA_MF) begin
          tx_ila  <= 1'b0;
          tx_data <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (core_rst);

  sequence s_ev3;
    evt && ctrl_q.sysref_delay == 4'h3 && ctrl_q.realign_every &&
    !ctrl_q.subclass2 ##1 $stable(ctrl_q) [*3];
  endsequence

  a_first_only: assert property (
    seen_q && !ctrl_q.realign_every && evt_dly && !lmfc_wrap
    |=> lmfc_cnt_q != '0)
    else $error("later sysref realigned lmfc");
  a_every_event: assert property (
    ctrl_q.realign_every && !ctrl_q.subclass2 && evt_dly
    |=> lmfc_cnt_q == '0 ##1 lmfc_cnt_q == LMFC_W'(1))
    else $error("sysref event did not realign lmfc");
  a_delay_three: assert property (s_ev3 |=> lmfc_cnt_q == '0)
    else $error("sysref delay of three not honoured");
  a_sync_held: assert property (
    !seen_q && !ctrl_q.subclass2 && $stable(ctrl_q) |-> !rx_sync_n)
    else $error("sync released before sysref");
  a_sync_bound: assert property (
    $rose(rx_sync_n) && !ctrl_q.subclass2
    |-> $past(lmfc_wrap) && $past(cgs_done))
    else $error("sync released off lmfc boundary");
  a_resync_hold: assert property (
    rx_resync && ctrl_q.event_needed_on_resync && !ctrl_q.subclass2
    |=> !rx_sync_n [*3])
    else $error("sync released too soon after resync");
  a_ila_bound: assert property (
    $rose(tx_ila) |-> $past(lmfc_wrap) && $past(sync_n_in))
    else $error("ila started off lmfc boundary");
  a_ila_ref: assert property (
    (tx_ila || tx_data) && $stable(ctrl_q) |-> seen_q || ctrl_q.subclass2)
    else $error("tx started without sysref");
  a_release_bound: assert property (
    $rose(rx_rel_q) |-> $past(lmfc_wrap) && $past(lanes_valid))
    else $error("rx data released off lmfc boundary");
  a_lmfc_step: assert property (
    !accept && !lmfc_wrap |=> lmfc_cnt_q == $past(lmfc_cnt_q) + LMFC_W'(1))
    else $error("lmfc did not advance one word");

endmodule
`default_nettype wire

//--- tb/sla_conv_model.sv
// Purpose: converter and sysref source facing the alignment block
// Assumes: one-shot sysref for each fire pulse
// Notes:   lat slows code group sync and the far sync release
`timescale 1ns/100ps
`default_nettype none
module sla_conv_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       fire,
  input  wire logic [3:0] lat,
  input  wire logic       cgs_in,
  input  wire logic       far_rel,
  input  wire logic       rx_sync_n,
  output logic            sysref,
  output logic            cgs_done,
  output logic            lanes_valid,
  output logic            sync_n_in
);
  logic       ref_q;
  logic [3:0] cgs_q;
  logic [3:0] far_q;
  // gated by reset so no event lands while the core is held
  assign sysref      = aresetn && ref_q;
  assign cgs_done    = cgs_in && (cgs_q >= lat);
  // lanes carry data only once our sync is released
  assign lanes_valid = cgs_done && rx_sync_n;
  assign sync_n_in   = far_rel && (far_q >= lat);
  // one pulse per fire, never a free train that drifts off the multiframe
  always_ff @(posedge aclk) begin
    ref_q <= fire;
  end
  always_ff @(posedge aclk) begin
    cgs_q <= !cgs_in ? 4'h0 : (cgs_q >= lat) ? cgs_q : cgs_q + 4'h1;
  end
  always_ff @(posedge aclk) begin
    far_q <= !far_rel ? 4'h0 : (far_q >= lat) ? far_q : far_q + 4'h1;
  end
endmodule
`default_nettype wire

//--- tb/sla_core_tb.sv
// Purpose: self-checking bench for sla_core
// Assumes: soft reset after each mode or delay change made through set_ctrl
// Notes:   lmfc phase taken modulo a 16-word multiframe
`timescale 1ns/100ps
`default_nettype none
module sla_core_tb;
  import sla_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [4:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
  } sla_row_t;
  localparam sla_row_t rows [10] = '{
    '{1'b0, SLA_CTRL_OFS, 32'h0000000A, SLA_RESP_OKAY},
    '{1'b0, SLA_PERIOD_OFS, 32'h00000007, SLA_RESP_OKAY},
    '{1'b0, 5'h10, 32'h00000000, SLA_RESP_DECERR},
    '{1'b0, 5'h1C, 32'h00000000, SLA_RESP_DECERR},
    '{1'b1, 5'h10, 32'h00000005, SLA_RESP_DECERR},
    '{1'b1, SLA_STATUS_OFS, 32'h000000FF, SLA_RESP_OKAY},
    '{1'b1, SLA_PERIOD_OFS, 32'h0000000F, SLA_RESP_OKAY},
    '{1'b0, SLA_PERIOD_OFS, 32'h0000000F, SLA_RESP_OKAY},
    '{1'b1, SLA_CTRL_OFS, 32'h0000020B, SLA_RESP_OKAY},
    '{1'b0, SLA_CTRL_OFS, 32'h0000000B, SLA_RESP_OKAY}
  };
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00;
  logic [4:0]  s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        rx_resync_req = 1'b0;
  logic        fire = 1'b0;
  logic        cgs_in = 1'b0;
  logic        far_rel = 1'b0;
  logic [3:0]  lat = 4'h3;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sysref, cgs_done, lanes_valid, sync_n_in;
  logic        rx_sync_n, rx_release, tx_ila, tx_data, lmfc_edge;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  int          cyc = 0, tf = 0, mismatches = 0, num_checks = 0;
  int          n, p1, p2, t1;
  int          ph [3];
  int          dly [3] = '{0, 3, 15};

  sla_core uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sysref, .cgs_done, .lanes_valid,
    .rx_resync_req, .sync_n_in, .rx_sync_n, .rx_release, .tx_ila,
    .tx_data, .lmfc_edge
  );
  sla_conv_model far (
    .aclk, .aresetn, .fire, .lat, .cgs_in, .far_rel, .rx_sync_n,
    .sysref, .cgs_done, .lanes_valid, .sync_n_in
  );

  always #4 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      mismatches++;
    end
  endtask

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // address channel stays refused until the response is taken
    chk({31'h0, s_axi_awready}, 32'h0);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk({31'h0, s_axi_arready}, 32'h0);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: sig = rx_sync_n;
      1: sig = tx_ila;
      2: sig = tx_data;
      3: sig = rx_release;
      4: sig = lmfc_edge;
      default: sig = tx_ila | tx_data;
    endcase
  endfunction

  // bounded wait, n holds the edges spent
  task automatic wait_for(input int w, input logic v, input int m);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sig(w) !== v && n < m);
    chk({31'h0, sig(w)}, {31'h0, v});
  endtask

  task automatic pulse;
    @(posedge aclk);
    tf = cyc;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask

  task automatic resync;
    rx_resync_req <= 1'b1;
    @(posedge aclk);
    rx_resync_req <= 1'b0;
  endtask

  // a firing a whole number of multiframes after the last would hide a realign
  task automatic measure(output int p);
    @(posedge aclk);
    if (((cyc - tf + 1) % 16) == 0) @(posedge aclk);
    pulse;
    repeat (40) @(posedge aclk);
    wait_for(4, 1'b1, 20);
    p = (cyc - tf) % 16;
  endtask

  task automatic set_ctrl(input logic [31:0] d);
    axi_wr(SLA_CTRL_OFS, d, rsp);
    repeat (4) @(posedge aclk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d, rsp);
      end else begin
        axi_rd(rows[i].a, rd, rsp);
        chk(rd, rows[i].d);
      end
      chk({30'h0, rsp}, {30'h0, rows[i].r});
    end
    done("registers");
    cgs_in  <= 1'b1;
    far_rel <= 1'b1;
    repeat (50) @(posedge aclk);
    chk({31'h0, rx_sync_n}, 32'h0);
    chk({31'h0, tx_ila}, 32'h0);
    pulse;
    wait_for(1, 1'b1, 60);
    wait_for(2, 1'b1, 80);
    chk(n, 64);
    wait_for(0, 1'b1, 1);
    wait_for(3, 1'b1, 40);
    wait_for(4, 1'b1, 20);
    wait_for(4, 1'b1, 20);
    chk(n, 16);
    done("bring-up");
    for (int i = 0; i < 3; i++) begin
      set_ctrl(32'h00000103 | (dly[i] << 4));
      measure(ph[i]);
      chk((ph[i] - ph[0] + 16) % 16, dly[i]);
    end
    measure(p2);
    chk(p2, ph[2]);
    // ila enabled so the resync below restarts with the sequence
    set_ctrl(32'h00000108);
    measure(p1);
    chk(p1, ph[0]);
    t1 = tf;
    measure(p2);
    chk(p2, (p1 - (tf - t1) % 16 + 16) % 16);
    done("sysref delay and realign");
    wait_for(0, 1'b1, 60);
    wait_for(5, 1'b1, 60);
    resync;
    wait_for(0, 1'b0, 8);
    wait_for(0, 1'b1, 40);
    far_rel <= 1'b0;
    wait_for(5, 1'b0, 8);
    far_rel <= 1'b1;
    wait_for(1, 1'b1, 40);
    set_ctrl(32'h0000010A);
    pulse;
    wait_for(0, 1'b1, 60);
    wait_for(5, 1'b1, 60);
    // both halves drop together, so tx never runs on a cleared record
    far_rel <= 1'b0;
    resync;
    repeat (60) @(posedge aclk);
    far_rel <= 1'b1;
    repeat (40) @(posedge aclk);
    chk({31'h0, rx_sync_n}, 32'h0);
    chk({31'h0, sig(5)}, 32'h0);
    pulse;
    wait_for(0, 1'b1, 60);
    wait_for(1, 1'b1, 60);
    done("resync");
    lat <= 4'h0;
    set_ctrl(32'h00000104);
    wait_for(0, 1'b1, 60);
    wait_for(2, 1'b1, 60);
    chk({31'h0, tx_ila}, 32'h0);
    set_ctrl(32'h0000010C);
    wait_for(1, 1'b1, 60);
    done("subclass 2");
    tally_and_finish;
  end

  // whole run is well under the 10000-cycle limit
  initial begin
    #(10000 * 8);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
